/* File: nbr_fifo.sv */
// Synchronous FIFO that buffers bytes read from the flash.
`timescale 1ns/10ps
module nbr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock, reset and enable.
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // Write side.
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Read side.
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    // Storage array.
    logic [WIDTH-1:0] mem [DEPTH];
    // Pointers and occupancy.
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_out = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Store incoming words.
    always_ff @(posedge clk_in) begin
        if (ce_in && push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // Move pointers and count.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (ce_in) begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : nbr_fifo

/* File: nbr_flash_model.sv */
// Behavioural flash device answering page, column and cache reads.
`timescale 1ns/10ps
module nbr_flash_model #(
    parameter int LOAD_CYC = 20
) (
    // Clock for busy timing and slow-answer control.
    input wire logic clk_in,
    input wire logic slow_in,
    // Flash pins as seen by the device.
    input wire logic chip_sel_n_in,
    input wire logic cmd_latch_in,
    input wire logic addr_latch_in,
    input wire logic write_strobe_n_in,
    input wire logic output_strobe_n_in,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic ready_busy_out
);
    logic [7:0] adr [4]; // Address bytes in arrival order.
    int acnt = 0;
    logic [15:0] fetch_row = 16'h0000; // Power-up page already read.
    logic [15:0] out_row = 16'h0000;
    logic [11:0] col = 12'h000;
    logic busy = 1'b0;
    event load_ev;
    initial io_out = 8'hA5;
    // The pull-up takes the line high once released.
    assign ready_busy_out = !busy;
    // Commands and addresses latch on the write strobe rise; busy ignores all.
    always @(posedge write_strobe_n_in) begin
        if (!chip_sel_n_in && output_strobe_n_in && !busy) begin
            if (addr_latch_in && !cmd_latch_in && acnt < 4) begin
                adr[acnt] = io_in; // Low byte first.
                acnt++;
            end else if (cmd_latch_in && !addr_latch_in) begin
                case (io_in)
                    8'h30: begin
                        fetch_row = {adr[3], adr[2]};
                        out_row = fetch_row;
                        col = {adr[1][3:0], adr[0]};
                        -> load_ev;
                    end
                    8'hE0: col = {adr[1][3:0], adr[0]};
                    8'h31: begin
                        out_row = fetch_row;
                        fetch_row = (acnt == 4) ? {adr[3], adr[2]} : fetch_row + 16'h0001;
                        col = 12'h000;
                        -> load_ev;
                    end
                    8'h3F: begin
                        out_row = fetch_row;
                        col = 12'h000;
                        -> load_ev;
                    end
                    default: ;
                endcase
                acnt = 0;
            end
        end
    end
    // Busy lasts the load time, four times longer when asked to be slow.
    always begin
        @(load_ev);
        busy = 1'b1;
        repeat (slow_in ? 4 * LOAD_CYC : LOAD_CYC) @(posedge clk_in);
        busy = 1'b0;
    end
    // Each read strobe fall puts out the next column; select may toggle between.
    always @(negedge output_strobe_n_in) begin
        if (!chip_sel_n_in && !busy) begin
            io_out = out_row[7:0] ^ col[7:0] ^ {4'h0, col[11:8]};
            col = col + 12'h001;
        end
    end
    // A released bus shows the inverse, so a stale capture is caught.
    always @(posedge output_strobe_n_in) io_out = #1 ~io_out;
endmodule : nbr_flash_model

/* File: nbr_host.sv */
// Host controller that drives flash strobes for page, column and cache reads.
`timescale 1ns/10ps
module nbr_host
    import nbr_pkg::*;
#(
    parameter int LOAD_TIMEOUT_CYC = ARRAY_LOAD_CYC,
    parameter int FIFO_DEPTH = 16
) (
    // Clock, reset and enable.
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // User request port.
    input wire logic req_valid_in,
    input wire nbr_op_t req_op_in,
    input wire logic req_addr_given_in,
    input wire logic [COL_BITS-1:0] req_col_in,
    input wire logic [ROW_BITS-1:0] req_row_in,
    input wire logic [15:0] req_len_in,
    output logic req_ready_out,
    output logic timeout_out,
    // User data stream.
    output logic data_valid_out,
    input wire logic data_ready_in,
    output logic [7:0] data_out,
    // Flash pins.
    output logic chip_sel_n_out,
    output logic cmd_latch_out,
    output logic addr_latch_out,
    output logic write_strobe_n_out,
    output logic output_strobe_n_out,
    output logic write_protect_n_out,
    input wire logic ready_busy_in,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic io_oe_out
);
    // Sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE, ST_SETUP, ST_WLOW, ST_WHIGH, ST_BUSYWAIT,
        ST_RLOW, ST_RHIGH, ST_DONE
    } nbr_state_t;

    nbr_state_t state;
    // Byte sequence to send: up to two commands and four addresses.
    logic [7:0] seq_byte [6];
    logic [5:0] seq_is_cmd;
    logic [2:0] seq_len;
    logic [2:0] seq_idx;
    logic wait_busy;
    // Timing counter and bytes still to read.
    logic [15:0] tmr;
    logic [15:0] remain;
    logic fifo_ready;
    logic fifo_push;
    logic [7:0] fifo_byte;
    // Head word of the buffer and the move into the output stage.
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic fifo_take;

    // Saturating remaining bytes from a column to page end.
    function automatic logic [15:0] span(input logic [COL_BITS-1:0] col, input logic [15:0] len);
        logic [15:0] left;
        left = PAGE_BYTES - 16'(col);
        span = (len == 16'h0000 || len > left) ? left : len;
    endfunction : span

    //////////////////////////////////////////////////////////////////////////////////
    // Request decode: build the byte list for each operation.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            // Clear the byte list so no stale command is replayed.
            seq_len <= '0;
            seq_is_cmd <= '0;
            wait_busy <= 1'b0;
            remain <= '0;
            for (int i = 0; i < 6; i++) begin
                seq_byte[i] <= 8'h00;
            end
        end else if (ce_in && state == ST_IDLE && req_valid_in) begin
            // Column bytes first, then row bytes, each low byte first.
            seq_byte[1] <= req_col_in[7:0];
            seq_byte[2] <= {4'h0, req_col_in[11:8]};
            seq_byte[3] <= req_row_in[7:0];
            seq_byte[4] <= req_row_in[15:8];
            seq_is_cmd <= 6'h21;
            case (req_op_in)
                NBR_OP_PAGE: begin
                    // Page read: 00H, four addresses, 30H, then wait for the load.
                    seq_byte[0] <= CMD_READ_SETUP;
                    seq_byte[5] <= CMD_READ_CONFIRM;
                    seq_len <= 3'd6;
                    wait_busy <= 1'b1;
                    remain <= span(req_col_in, req_len_in);
                end
                NBR_OP_COLUMN: begin
                    // Column change sends only two address bytes.
                    seq_byte[0] <= CMD_COL_SETUP;
                    seq_byte[3] <= CMD_COL_CONFIRM;
                    seq_is_cmd <= 6'h09;
                    seq_len <= 3'd4;
                    wait_busy <= 1'b0;
                    remain <= span(req_col_in, req_len_in);
                end
                NBR_OP_CACHE: begin
                    // Cache read: optional address, then 31H; output from column zero.
                    wait_busy <= 1'b1;
                    remain <= span('0, req_len_in);
                    if (req_addr_given_in) begin
                        // A given address goes out as 00H, four bytes, then 31H.
                        seq_byte[0] <= CMD_READ_SETUP;
                        seq_byte[5] <= CMD_CACHE_NEXT;
                        seq_len <= 3'd6;
                    end else begin
                        // Without an address the flash fetches the next page.
                        seq_byte[0] <= CMD_CACHE_NEXT;
                        seq_is_cmd <= 6'h01;
                        seq_len <= 3'd1;
                    end
                end
                default: begin
                    // Cache end: a bare 3FH copies the final page.
                    seq_byte[0] <= CMD_CACHE_END;
                    seq_is_cmd <= 6'h01;
                    seq_len <= 3'd1;
                    wait_busy <= 1'b1;
                    remain <= span('0, req_len_in);
                end
            endcase
        end else if (ce_in && fifo_push) begin
            // Each captured byte lowers the count still to read.
            remain <= remain - 16'h0001;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Strobe sequencer.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            // The sequencer starts idle with no timeout flagged.
            state <= ST_IDLE;
            seq_idx <= '0;
            tmr <= '0;
            timeout_out <= 1'b0;
        end else if (ce_in) begin
            case (state)
                ST_IDLE: begin
                    // Wait for a request; the decode block loads the byte list meanwhile.
                    if (req_valid_in) begin
                        seq_idx <= '0;
                        timeout_out <= 1'b0;
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // Latch levels settle before the write strobe falls.
                    tmr <= 16'(STROBE_LOW_CYC);
                    state <= ST_WLOW;
                end
                ST_WLOW: begin
                    // Write strobe low phase; the byte already stands on the bus.
                    if (tmr <= 16'h0001) begin
                        tmr <= 16'(STROBE_HIGH_CYC);
                        state <= ST_WHIGH;
                    end else begin
                        tmr <= tmr - 16'h0001;
                    end
                end
                ST_WHIGH: begin
                    // Rising write strobe latches the byte; hold then advance.
                    if (tmr <= 16'h0001) begin
                        if (seq_idx == seq_len - 3'd1) begin
                            // Last byte sent: wait for the load or go straight to output.
                            tmr <= 16'(LOAD_TIMEOUT_CYC);
                            state <= wait_busy ? ST_BUSYWAIT : ST_RHIGH;
                        end else begin
                            // More bytes follow: set up the next one.
                            seq_idx <= seq_idx + 3'd1;
                            state <= ST_SETUP;
                        end
                    end else begin
                        tmr <= tmr - 16'h0001;
                    end
                end
                ST_BUSYWAIT: begin
                    // Strobes stay high while the array loads.
                    if (tmr < 16'(LOAD_TIMEOUT_CYC - SETTLE_CYC) && ready_busy_in) begin
                        tmr <= 16'(STROBE_HIGH_CYC);
                        state <= ST_RHIGH;
                    end else if (tmr == 16'h0000) begin
                        timeout_out <= 1'b1;
                        state <= ST_DONE;
                    end else begin
                        tmr <= tmr - 16'h0001;
                    end
                end
                ST_RHIGH: begin
                    // Pull a word only when the FIFO has room.
                    if (remain == 16'h0000) begin
                        state <= ST_DONE;
                    end else if (tmr <= 16'h0001 && fifo_ready) begin
                        tmr <= 16'(STROBE_LOW_CYC);
                        state <= ST_RLOW;
                    end else if (tmr > 16'h0001) begin
                        // Hold the strobe high for its minimum time.
                        tmr <= tmr - 16'h0001;
                    end
                end
                ST_RLOW: begin
                    // Sample before the rising edge; cycles stay slow.
                    if (tmr <= 16'h0001) begin
                        tmr <= 16'(STROBE_HIGH_CYC);
                        state <= ST_RHIGH;
                    end else begin
                        tmr <= tmr - 16'h0001;
                    end
                end
                ST_DONE: begin
                    // One cycle here before idle; select rises on the same clock edge as ready.
                    state <= ST_IDLE;
                end
                default: begin
                    // An illegal state falls back to idle.
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Pin drivers, all registered.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            // Pins rest deselected and protected, with the bus released.
            chip_sel_n_out <= 1'b1;
            cmd_latch_out <= 1'b0;
            addr_latch_out <= 1'b0;
            write_strobe_n_out <= 1'b1;
            output_strobe_n_out <= 1'b1;
            write_protect_n_out <= 1'b0;
            io_out <= 8'h00;
            io_oe_out <= 1'b0;
            req_ready_out <= 1'b0;
        end else if (ce_in) begin
            // Reads never program, so protect stays asserted.
            write_protect_n_out <= 1'b0;
            // Select held low for the whole operation, so timing margins hold.
            chip_sel_n_out <= (state == ST_IDLE);
            req_ready_out <= (state == ST_IDLE) && !req_valid_in;
            if (state == ST_SETUP || state == ST_WLOW || state == ST_WHIGH) begin
                // Drive the current byte and its latch through the write phases.
                cmd_latch_out <= seq_is_cmd[seq_idx];
                addr_latch_out <= !seq_is_cmd[seq_idx];
                io_out <= seq_byte[seq_idx];
                io_oe_out <= 1'b1;
            end else begin
                // Latches drop and the bus is released outside the write phases.
                cmd_latch_out <= 1'b0;
                addr_latch_out <= 1'b0;
                io_oe_out <= 1'b0;
            end
            // Each strobe is low only in its own low phase.
            write_strobe_n_out <= !(state == ST_WLOW);
            output_strobe_n_out <= !(state == ST_RLOW);
        end
    end

    // Capture the word on the last cycle of ST_RLOW, one clock before the read strobe rises.
    assign fifo_push = (state == ST_RLOW) && (tmr <= 16'h0001) && ce_in;
    assign fifo_byte = io_in;

    //////////////////////////////////////////////////////////////////////////////////
    // Output stage: the stream leaves the block straight from flip-flops.
    // A word moves up when the stage is empty or is being emptied this cycle.
    assign fifo_take = fifo_valid && (!data_valid_out || data_ready_in);

    // Valid flag of the output stage.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            data_valid_out <= 1'b0;
        end else if (ce_in) begin
            if (fifo_take) begin
                // A fresh word replaces the one just taken.
                data_valid_out <= 1'b1;
            end else if (data_ready_in) begin
                // The sink took the last word and nothing follows.
                data_valid_out <= 1'b0;
            end
        end
    end

    // Data word of the output stage; it moves only with a fresh word.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            data_out <= 8'h00;
        end else if (ce_in && fifo_take) begin
            data_out <= fifo_data;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Read data buffer; a stalled sink stops the read strobe.
    nbr_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .in_valid_in(fifo_push),
        .in_ready_out(fifo_ready),
        .in_data_in(fifo_byte),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_take),
        .out_data_out(fifo_data)
    );
endmodule : nbr_host

/* File: nbr_host_sva.sv */
// Checker of strobe, latch and bus timing at the flash pins of the read controller.
`timescale 1ns/10ps
module nbr_host_sva (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic srst_in,
    // Flash pins.
    input wire logic chip_sel_n_out,
    input wire logic cmd_latch_out,
    input wire logic addr_latch_out,
    input wire logic write_strobe_n_out,
    input wire logic output_strobe_n_out,
    input wire logic write_protect_n_out,
    input wire logic ready_busy_in,
    input wire logic [7:0] io_out,
    input wire logic io_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // A strobe pulse is two low cycles and then a rise.
    sequence we_pulse_s;
        !write_strobe_n_out [*2] ##1 write_strobe_n_out;
    endsequence
    sequence re_pulse_s;
        !output_strobe_n_out [*2] ##1 output_strobe_n_out;
    endsequence
    latch_excl_a: assert property (!(cmd_latch_out && addr_latch_out))
        else $error("Both latch enables high.");
    we_width_a: assert property ($fell(write_strobe_n_out) |-> we_pulse_s)
        else $error("Write strobe pulse has the wrong width.");
    re_width_a: assert property ($fell(output_strobe_n_out) |-> re_pulse_s)
        else $error("Read strobe pulse has the wrong width.");
    we_qualify_a: assert property (!write_strobe_n_out |->
        !chip_sel_n_out && output_strobe_n_out && io_oe_out)
        else $error("Write strobe low without select or bus drive.");
    we_hold_a: assert property ($rose(write_strobe_n_out) |-> $stable(io_out) &&
        $stable(cmd_latch_out) && $stable(addr_latch_out))
        else $error("Bus or latch changed at the write strobe rise.");
    busy_quiet_a: assert property (!ready_busy_in |->
        write_strobe_n_out && output_strobe_n_out)
        else $error("Strobe pulsed while the flash is busy.");
    re_bus_free_a: assert property (!output_strobe_n_out |-> !io_oe_out &&
        !cmd_latch_out && !addr_latch_out && !chip_sel_n_out)
        else $error("Bus driven or unselected during data output.");
    protect_low_a: assert property (write_protect_n_out == 1'b0)
        else $error("Write protect released during reads.");
endmodule : nbr_host_sva

/* File: nbr_pkg.sv */
// Package of command codes, address layout and timing counts for the flash read controller.
package nbr_pkg;
    // Command bytes of the read family.
    localparam logic [7:0] CMD_READ_SETUP = 8'h00;
    localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
    localparam logic [7:0] CMD_COL_SETUP = 8'h05;
    localparam logic [7:0] CMD_COL_CONFIRM = 8'hE0;
    localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
    localparam logic [7:0] CMD_CACHE_END = 8'h3F;
    // Address field layout for x8 organisation.
    localparam int COL_BITS = 12;
    localparam int ROW_BITS = 16;
    localparam int ADDR_CYCLES = 4;
    localparam int COL_CYCLES = 2;
    localparam logic [15:0] PAGE_BYTES = 16'h0880;
    // Clock period and pin timings in nanoseconds.
    localparam int CLK_PERIOD_NS = 10;
    localparam int STROBE_LOW_NS = 20;
    localparam int STROBE_HIGH_NS = 20;
    localparam int SETTLE_NS = 10;
    // Longest array load time in nanoseconds.
    localparam int ARRAY_LOAD_TIME_NS = 25000;
    // Least times round up to whole cycles.
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ARRAY_LOAD_CYC = (ARRAY_LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Host operations requested by the user.
    typedef enum logic [1:0] {
        NBR_OP_PAGE,
        NBR_OP_COLUMN,
        NBR_OP_CACHE,
        NBR_OP_CACHE_END
    } nbr_op_t;
endpackage : nbr_pkg

/* File: tb_top.sv */
// Self-checking bench of the flash read controller against a behavioural flash.
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; $display("FAIL %0t %s", $time, "mismatch"); end end
module tb_top;
    import nbr_pkg::*;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic ce_in = 1'b1;
    logic req_valid_in = 1'b0;
    nbr_op_t req_op_in = NBR_OP_PAGE;
    logic req_addr_given_in = 1'b0;
    logic [COL_BITS-1:0] req_col_in = '0;
    logic [ROW_BITS-1:0] req_row_in = '0;
    logic [15:0] req_len_in = 16'h0000;
    logic data_ready_in = 1'b1;
    logic slow = 1'b0;
    logic drop = 1'b0;
    logic stall = 1'b0;
    logic req_ready_out, timeout_out, data_valid_out, chip_sel_n_out, cmd_latch_out;
    logic addr_latch_out, write_strobe_n_out, output_strobe_n_out, write_protect_n_out;
    logic io_oe_out, ready_busy;
    logic [7:0] data_out, io_out, io_wire, dev_io;
    logic [7:0] exp_q [$];
    logic [15:0] row_a, row_b;
    logic [11:0] col_a;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int w;
    always #5 clk_in = ~clk_in;
    // The shared bus carries whichever side has it.
    assign io_wire = io_oe_out ? io_out : dev_io;
    nbr_host #(.LOAD_TIMEOUT_CYC(50), .FIFO_DEPTH(16)) u_dut (.clk_in(clk_in),
        .srst_in(srst_in), .ce_in(ce_in), .req_valid_in(req_valid_in), .req_op_in(req_op_in),
        .req_addr_given_in(req_addr_given_in), .req_col_in(req_col_in),
        .req_row_in(req_row_in), .req_len_in(req_len_in), .req_ready_out(req_ready_out),
        .timeout_out(timeout_out), .data_valid_out(data_valid_out),
        .data_ready_in(data_ready_in), .data_out(data_out), .chip_sel_n_out(chip_sel_n_out),
        .cmd_latch_out(cmd_latch_out), .addr_latch_out(addr_latch_out),
        .write_strobe_n_out(write_strobe_n_out), .output_strobe_n_out(output_strobe_n_out),
        .write_protect_n_out(write_protect_n_out), .ready_busy_in(ready_busy),
        .io_in(io_wire), .io_out(io_out), .io_oe_out(io_oe_out));
    nbr_flash_model #(.LOAD_CYC(20)) u_flash (.clk_in(clk_in), .slow_in(slow),
        .chip_sel_n_in(chip_sel_n_out), .cmd_latch_in(cmd_latch_out),
        .addr_latch_in(addr_latch_out), .write_strobe_n_in(write_strobe_n_out),
        .output_strobe_n_in(output_strobe_n_out), .io_in(io_wire), .io_out(dev_io),
        .ready_busy_out(ready_busy));
    // The reader stalls at random, and for long stretches when asked.
    always @(posedge clk_in) data_ready_in <= #1 stall ? 1'b0 : ($urandom % 4 != 0);
    // Each byte taken is compared with the oldest expectation.
    always @(posedge clk_in) begin
        if (data_valid_out === 1'b1 && data_ready_in === 1'b1 && !drop) begin
            `CHK(exp_q.size() > 0, 1'b1)
            if (exp_q.size() > 0) `CHK(data_out, exp_q.pop_front())
        end
    end
    task automatic wait_lvl(ref logic sig, input logic val);
        int k;
        k = 0;
        while (sig !== val && k < 3000) begin
            @(posedge clk_in);
            #1;
            k++;
        end
        if (k == 3000) begin
            error_cnt++;
            $display("FAIL %0t %s", $time, "handshake wait ran out");
        end
    endtask : wait_lvl
    // Notes the expected bytes, then hands one request to the controller.
    task automatic run_op(input nbr_op_t op, input logic given, input logic [11:0] col,
        input logic [15:0] row, input logic [15:0] len, input logic [15:0] erow,
        input logic [11:0] ecol);
        int n;
        logic [11:0] c;
        n = int'(PAGE_BYTES) - int'(ecol);
        if (len != 16'h0000 && int'(len) < n) n = int'(len);
        for (int k = 0; k < n && !drop; k++) begin
            c = ecol + 12'(k);
            exp_q.push_back(erow[7:0] ^ c[7:0] ^ {4'h0, c[11:8]});
        end
        @(posedge clk_in);
        #1;
        req_op_in = op;
        req_addr_given_in = given;
        req_col_in = col;
        req_row_in = row;
        req_len_in = len;
        req_valid_in = 1'b1;
        wait_lvl(chip_sel_n_out, 1'b0);
        req_valid_in = 1'b0;
        wait_lvl(req_ready_out, 1'b1);
    endtask : run_op
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        void'($urandom(68));
        repeat (20) @(posedge clk_in);
        #1;
        srst_in = 1'b0;
        repeat (2) @(posedge clk_in);
        row_a = 16'($urandom);
        row_b = 16'($urandom);
        col_a = 12'($urandom % 2000);
        run_op(NBR_OP_PAGE, 1'b0, col_a, row_a, 16'h0008, row_a, col_a);
        run_op(NBR_OP_COLUMN, 1'b0, 12'h87D, row_a, 16'h0000, row_a, 12'h87D);
        run_op(NBR_OP_CACHE, 1'b0, 12'h000, row_a, 16'h0004, row_a, 12'h000);
        run_op(NBR_OP_CACHE, 1'b1, 12'h000, row_b, 16'h0004, row_a + 16'h0001, 12'h000);
        run_op(NBR_OP_CACHE_END, 1'b0, 12'h000, row_a, 16'h0004, row_b, 12'h000);
        fork
            run_op(NBR_OP_PAGE, 1'b0, 12'h000, row_b, 16'h0014, row_b, 12'h000);
            begin
                stall = 1'b1;
                repeat (300) @(posedge clk_in);
                #1;
                `CHK(data_valid_out, 1'b1)
                stall = 1'b0;
            end
        join
        for (w = 0; w < 2000 && exp_q.size() != 0; w++) @(posedge clk_in);
        `CHK(exp_q.size(), 0)
        slow = 1'b1;
        drop = 1'b1;
        run_op(NBR_OP_PAGE, 1'b0, 12'h000, row_a, 16'h0001, row_a, 12'h000);
        `CHK(timeout_out, 1'b1)
        final_report();
    end
endmodule : tb_top
bind nbr_host nbr_host_sva u_sva (.clk_in(clk_in), .srst_in(srst_in),
    .chip_sel_n_out(chip_sel_n_out), .cmd_latch_out(cmd_latch_out),
    .addr_latch_out(addr_latch_out), .write_strobe_n_out(write_strobe_n_out),
    .output_strobe_n_out(output_strobe_n_out), .write_protect_n_out(write_protect_n_out),
    .ready_busy_in(ready_busy_in), .io_out(io_out), .io_oe_out(io_oe_out));
